/* File: design/ppmc_pkg.sv */
package ppmc_pkg;

    // ****************************************
    // Bus and register layout
    // ****************************************
    localparam int unsigned PORT_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;

    localparam logic [ADDR_W-1:0] OFS_CTRL_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_DIR_A = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DIR_B = 8'h05;
    localparam logic [ADDR_W-1:0] OFS_DIR_C = 8'h06;
    localparam logic [ADDR_W-1:0] OFS_DIR_D = 8'h07;
    localparam logic [ADDR_W-1:0] OFS_DRV_A = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DRV_B = 8'h09;
    localparam logic [ADDR_W-1:0] OFS_DRV_C = 8'h0A;
    localparam logic [ADDR_W-1:0] OFS_DRV_D = 8'h0B;
    localparam logic [ADDR_W-1:0] OFS_MEM_MAP = 8'h0C;

    // ****************************************
    // Field positions and pin masks
    // ****************************************
    localparam int unsigned PERIPH_EN_POS = 7;
    localparam logic [7:0] MEM_MAP_MASK = 8'h80;
    localparam logic [7:0] ALL_PINS = 8'hFF;
    localparam logic [7:0] NO_PINS = 8'h00;
    localparam logic [7:0] PD_IMPL_MASK = 8'h06;
    localparam logic [7:0] PC_SECOND_MASK = 8'h9C;
    localparam logic [7:0] PC_SCAN_MASK = 8'h63;
    localparam logic [7:0] AB_OD_MASK = 8'hF0;
    localparam logic [7:0] AB_SLEW_MASK = 8'h0F;
    localparam logic [7:0] C_OD_MASK = 8'hFF;
    localparam logic [7:0] D_SLEW_MASK = 8'h06;

    // ****************************************
    // Pin output source
    // ****************************************
    typedef enum logic [1:0] {
        PPMC_SRC_DATA = 2'b00,
        PPMC_SRC_CELL = 2'b01,
        PPMC_SRC_ADDR = 2'b10,
        PPMC_SRC_PERIPH = 2'b11
    } ppmc_src_e;

endpackage

/* File: design/ppmc_port_stage.sv */
module ppmc_port_stage
    import ppmc_pkg::*;
#(
    parameter int unsigned W = 8,
    parameter logic [7:0] IMPL_MASK = 8'hFF,
    parameter logic [7:0] OD_MASK = 8'h00,
    parameter logic [7:0] SLEW_MASK = 8'h00
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] mode_addr,
    input wire logic [W-1:0] dir,
    input wire logic [W-1:0] drive,
    input wire logic [W-1:0] oe_term,
    input wire logic [W-1:0] cell_sel,
    input wire logic [W-1:0] data_out,
    input wire logic [W-1:0] cell_out,
    input wire logic [W-1:0] addr,
    input wire logic periph_en,
    input wire logic periph_drive,
    input wire logic [W-1:0] periph_data,
    output logic [W-1:0] pin_out_q,
    output logic [W-1:0] pin_oe_n_q,
    output logic [W-1:0] fast_slew_q
);

    if (W < 1 || W > 8) begin : g_bad_width
        $error("ppmc_port_stage: width must be 1 to 8");
    end

    logic [W-1:0] pin_out_d;
    logic [W-1:0] pin_oe_n_d;
    logic [W-1:0] fast_slew_d;

    // ****************************************
    // Per-pin source select and driver enable
    // ****************************************
    for (genvar i = 0; i < W; i++) begin : g_pin
        ppmc_src_e src;
        logic val;
        logic en;
        always_comb begin
            if (periph_en) begin
                src = PPMC_SRC_PERIPH;
            end else if (mode_addr[i]) begin
                src = PPMC_SRC_ADDR; // RULE11
            end else if (cell_sel[i]) begin
                src = PPMC_SRC_CELL;
            end else begin
                src = PPMC_SRC_DATA; // RULE20
            end
            case (src)
                PPMC_SRC_PERIPH: begin
                    val = periph_data[i];
                    en = periph_drive; // RULE6
                end
                PPMC_SRC_ADDR: begin
                    val = addr[i]; // RULE4
                    en = oe_term[i] | (dir[i] & mode_addr[i]); // RULE3
                end
                PPMC_SRC_CELL: begin
                    val = cell_out[i];
                    en = oe_term[i] | dir[i]; // RULE1
                end
                default: begin
                    val = data_out[i];
                    en = dir[i] | oe_term[i]; // RULE13 RULE14 RULE12
                end
            endcase
            en = en & IMPL_MASK[i]; // RULE15 RULE19
            pin_out_d[i] = val;
            if (OD_MASK[i] && drive[i] && !periph_en) begin
                pin_oe_n_d[i] = ~(en & ~val); // RULE16
            end else begin
                pin_oe_n_d[i] = ~en;
            end
            fast_slew_d[i] = SLEW_MASK[i] & drive[i]; // RULE17
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_out_q <= '0;
            pin_oe_n_q <= '1;
            fast_slew_q <= '0;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
            fast_slew_q <= fast_slew_d;
        end
    end

endmodule

/* File: design/ppmc_port_ctrl.sv */
// Notes on behaviour
// RULE1 - Logic-mode driver off unless enable or direction
// RULE2 - Software keeps direction zero on logic inputs
// RULE3 - Address out needs enable, or direction and control
// RULE4 - Pins 3..0 carry a3-a0, 7..4 a7-a4
// RULE5 - Mode bit 7 makes Port A bus buffer
// RULE6 - Buffer drives only while a select active
// RULE7 - Select equations should include program strobe
// RULE8 - Registers read and written by bus cycles
// RULE9 - Bit n controls pin n only
// RULE10 - All configuration registers clear at reset
// RULE11 - Control 0 register I/O, 1 address out
// RULE12 - Direction 1 output, 0 input
// RULE13 - Enable is direction OR logic enable term
// RULE14 - Without enable term, direction alone decides
// RULE15 - Port D direction has two bits only
// RULE16 - Drive bit 1 selects open drain
// RULE17 - Drive bit 1 selects fast slew
// RULE18 - Port C takes second group on 2,3,4,7
// RULE19 - Port C scan pins unavailable to port
// RULE20 - Data register drives when enabled, stays readable
// RULE21 - Reads return written bits, others zero
module ppmc_port_ctrl
    import ppmc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata_q,
    input wire logic [7:0] latched_addr,
    input wire logic periph_select_a,
    input wire logic periph_select_b,
    output logic [7:0] periph_rdata_q,
    input wire logic [7:0] data_out_a,
    input wire logic [7:0] data_out_b,
    input wire logic [7:0] data_out_c,
    input wire logic [7:0] data_out_d,
    input wire logic [7:0] oe_term_a,
    input wire logic [7:0] oe_term_b,
    input wire logic [7:0] oe_term_c,
    input wire logic [7:0] oe_term_d,
    input wire logic [7:0] cell_sel_a,
    input wire logic [7:0] cell_sel_b,
    input wire logic [7:0] cell_sel_c,
    input wire logic [7:0] out_cell_group_first,
    input wire logic [7:0] out_cell_group_second,
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out_q,
    output logic [7:0] pa_oe_n_q,
    output logic [7:0] pa_fast_slew_q,
    output logic [7:0] pb_out_q,
    output logic [7:0] pb_oe_n_q,
    output logic [7:0] pb_fast_slew_q,
    output logic [7:0] pc_out_q,
    output logic [7:0] pc_oe_n_q,
    output logic [7:0] pd_out_q,
    output logic [7:0] pd_oe_n_q,
    output logic [7:0] pd_fast_slew_q
);

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [7:0] ctrl_a_q, ctrl_a_d;
    logic [7:0] ctrl_b_q, ctrl_b_d;
    logic [7:0] dir_a_q, dir_a_d;
    logic [7:0] dir_b_q, dir_b_d;
    logic [7:0] dir_c_q, dir_c_d;
    logic [7:0] dir_d_q, dir_d_d;
    logic [7:0] drv_a_q, drv_a_d;
    logic [7:0] drv_b_q, drv_b_d;
    logic [7:0] drv_c_q, drv_c_d;
    logic [7:0] drv_d_q, drv_d_d;
    logic [7:0] mem_map_q, mem_map_d;
    logic [7:0] bus_rdata_d;

    always_comb begin
        ctrl_a_d = ctrl_a_q;
        ctrl_b_d = ctrl_b_q;
        dir_a_d = dir_a_q;
        dir_b_d = dir_b_q;
        dir_c_d = dir_c_q;
        dir_d_d = dir_d_q;
        drv_a_d = drv_a_q;
        drv_b_d = drv_b_q;
        drv_c_d = drv_c_q;
        drv_d_d = drv_d_q;
        mem_map_d = mem_map_q;
        if (bus_wr) begin // RULE8 RULE9
            if (bus_addr == OFS_CTRL_A) begin
                ctrl_a_d = bus_wdata;
            end else if (bus_addr == OFS_CTRL_B) begin
                ctrl_b_d = bus_wdata;
            end else if (bus_addr == OFS_DIR_A) begin
                dir_a_d = bus_wdata;
            end else if (bus_addr == OFS_DIR_B) begin
                dir_b_d = bus_wdata;
            end else if (bus_addr == OFS_DIR_C) begin
                dir_c_d = bus_wdata;
            end else if (bus_addr == OFS_DIR_D) begin
                dir_d_d = bus_wdata & PD_IMPL_MASK; // RULE15
            end else if (bus_addr == OFS_DRV_A) begin
                drv_a_d = bus_wdata;
            end else if (bus_addr == OFS_DRV_B) begin
                drv_b_d = bus_wdata;
            end else if (bus_addr == OFS_DRV_C) begin
                drv_c_d = bus_wdata;
            end else if (bus_addr == OFS_DRV_D) begin
                drv_d_d = bus_wdata & D_SLEW_MASK;
            end else if (bus_addr == OFS_MEM_MAP) begin
                mem_map_d = bus_wdata & MEM_MAP_MASK;
            end
        end
    end

    // ****************************************
    // Register read-back
    // ****************************************
    always_comb begin
        bus_rdata_d = bus_rdata_q;
        if (bus_rd) begin // RULE21
            if (bus_addr == OFS_CTRL_A) begin
                bus_rdata_d = ctrl_a_q;
            end else if (bus_addr == OFS_CTRL_B) begin
                bus_rdata_d = ctrl_b_q;
            end else if (bus_addr == OFS_DIR_A) begin
                bus_rdata_d = dir_a_q;
            end else if (bus_addr == OFS_DIR_B) begin
                bus_rdata_d = dir_b_q;
            end else if (bus_addr == OFS_DIR_C) begin
                bus_rdata_d = dir_c_q;
            end else if (bus_addr == OFS_DIR_D) begin
                bus_rdata_d = dir_d_q;
            end else if (bus_addr == OFS_DRV_A) begin
                bus_rdata_d = drv_a_q;
            end else if (bus_addr == OFS_DRV_B) begin
                bus_rdata_d = drv_b_q;
            end else if (bus_addr == OFS_DRV_C) begin
                bus_rdata_d = drv_c_q;
            end else if (bus_addr == OFS_DRV_D) begin
                bus_rdata_d = drv_d_q;
            end else if (bus_addr == OFS_MEM_MAP) begin
                bus_rdata_d = mem_map_q;
            end else begin
                bus_rdata_d = CFG_RESET;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin // RULE10
            ctrl_a_q <= CFG_RESET;
            ctrl_b_q <= CFG_RESET;
            dir_a_q <= CFG_RESET;
            dir_b_q <= CFG_RESET;
            dir_c_q <= CFG_RESET;
            dir_d_q <= CFG_RESET;
            drv_a_q <= CFG_RESET;
            drv_b_q <= CFG_RESET;
            drv_c_q <= CFG_RESET;
            drv_d_q <= CFG_RESET;
            mem_map_q <= CFG_RESET;
            bus_rdata_q <= CFG_RESET;
        end else begin
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            dir_a_q <= dir_a_d;
            dir_b_q <= dir_b_d;
            dir_c_q <= dir_c_d;
            dir_d_q <= dir_d_d;
            drv_a_q <= drv_a_d;
            drv_b_q <= drv_b_d;
            drv_c_q <= drv_c_d;
            drv_d_q <= drv_d_d;
            mem_map_q <= mem_map_d;
            bus_rdata_q <= bus_rdata_d;
        end
    end

    // ****************************************
    // Peripheral buffer on Port A
    // ****************************************
    logic periph_buffer_enable_bit;
    logic periph_active;
    logic periph_drive;
    logic [7:0] pa_sync1_q, pa_sync2_q;
    logic [7:0] periph_rdata_d;

    assign periph_buffer_enable_bit = mem_map_q[PERIPH_EN_POS]; // RULE5
    assign periph_active = periph_buffer_enable_bit & (periph_select_a | periph_select_b); // RULE6
    assign periph_drive = periph_active & bus_wr;

    always_comb begin
        periph_rdata_d = periph_rdata_q;
        if (periph_active && bus_rd) begin
            periph_rdata_d = pa_sync2_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pa_sync1_q <= '0;
            pa_sync2_q <= '0;
            periph_rdata_q <= '0;
        end else begin
            pa_sync1_q <= pa_in;
            pa_sync2_q <= pa_sync1_q;
            periph_rdata_q <= periph_rdata_d;
        end
    end

    // ****************************************
    // Port output stages
    // ****************************************
    ppmc_port_stage #(
        .W(8),
        .IMPL_MASK(ALL_PINS),
        .OD_MASK(AB_OD_MASK),
        .SLEW_MASK(AB_SLEW_MASK)
    ) u_port_a (
        .clock(clock),
        .rst_n(rst_n),
        .mode_addr(ctrl_a_q),
        .dir(dir_a_q),
        .drive(drv_a_q),
        .oe_term(oe_term_a),
        .cell_sel(cell_sel_a),
        .data_out(data_out_a),
        .cell_out(out_cell_group_first),
        .addr(latched_addr),
        .periph_en(periph_buffer_enable_bit),
        .periph_drive(periph_drive),
        .periph_data(bus_wdata),
        .pin_out_q(pa_out_q),
        .pin_oe_n_q(pa_oe_n_q),
        .fast_slew_q(pa_fast_slew_q)
    );

    ppmc_port_stage #(
        .W(8),
        .IMPL_MASK(ALL_PINS),
        .OD_MASK(AB_OD_MASK),
        .SLEW_MASK(AB_SLEW_MASK)
    ) u_port_b (
        .clock(clock),
        .rst_n(rst_n),
        .mode_addr(ctrl_b_q),
        .dir(dir_b_q),
        .drive(drv_b_q),
        .oe_term(oe_term_b),
        .cell_sel(cell_sel_b),
        .data_out(data_out_b),
        .cell_out(out_cell_group_second),
        .addr(latched_addr),
        .periph_en(1'b0),
        .periph_drive(1'b0),
        .periph_data(8'h00),
        .pin_out_q(pb_out_q),
        .pin_oe_n_q(pb_oe_n_q),
        .fast_slew_q(pb_fast_slew_q)
    );

    ppmc_port_stage #(
        .W(8),
        .IMPL_MASK(~PC_SCAN_MASK),
        .OD_MASK(C_OD_MASK),
        .SLEW_MASK(NO_PINS)
    ) u_port_c (
        .clock(clock),
        .rst_n(rst_n),
        .mode_addr(8'h00),
        .dir(dir_c_q),
        .drive(drv_c_q),
        .oe_term(oe_term_c),
        .cell_sel(cell_sel_c & PC_SECOND_MASK), // RULE18
        .data_out(data_out_c),
        .cell_out(out_cell_group_second),
        .addr(8'h00),
        .periph_en(1'b0),
        .periph_drive(1'b0),
        .periph_data(8'h00),
        .pin_out_q(pc_out_q),
        .pin_oe_n_q(pc_oe_n_q),
        .fast_slew_q()
    );

    ppmc_port_stage #(
        .W(8),
        .IMPL_MASK(PD_IMPL_MASK),
        .OD_MASK(NO_PINS),
        .SLEW_MASK(D_SLEW_MASK)
    ) u_port_d (
        .clock(clock),
        .rst_n(rst_n),
        .mode_addr(8'h00),
        .dir(dir_d_q),
        .drive(drv_d_q),
        .oe_term(oe_term_d),
        .cell_sel(8'h00),
        .data_out(data_out_d),
        .cell_out(8'h00),
        .addr(8'h00),
        .periph_en(1'b0),
        .periph_drive(1'b0),
        .periph_data(8'h00),
        .pin_out_q(pd_out_q),
        .pin_oe_n_q(pd_oe_n_q),
        .fast_slew_q(pd_fast_slew_q)
    );

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_dir_d_write;
        bus_wr && bus_addr == OFS_DIR_D;
    endsequence

    sequence s_dir_d_read;
        bus_rd && !bus_wr && bus_addr == OFS_DIR_D;
    endsequence

    a_reset_clears: assert property (disable iff (1'b0)
        !rst_n |=> (dir_a_q == CFG_RESET && ctrl_b_q == CFG_RESET && drv_c_q == CFG_RESET
            && pa_oe_n_q == ALL_PINS)) // RULE10
        else $error("configuration not cleared by reset");

    a_readback_dir_d: assert property (
        s_dir_d_write ##1 !bus_wr ##1 s_dir_d_read |=> bus_rdata_q == ($past(bus_wdata, 3) & PD_IMPL_MASK)) // RULE21
        else $error("direction D read-back mismatch");

    a_port_d_enable: assert property (
        pd_oe_n_q == ~($past(dir_d_q | oe_term_d) & PD_IMPL_MASK)) // RULE13
        else $error("port D enable is not direction OR term");

    a_logic_tristate: assert property (
        (dir_c_q == 8'h00 && oe_term_c == 8'h00) |=> pc_oe_n_q == ALL_PINS) // RULE1
        else $error("port C driven without direction or term");

    a_periph_idle: assert property (
        (mem_map_q[PERIPH_EN_POS] && !periph_select_a && !periph_select_b) |=> pa_oe_n_q == ALL_PINS) // RULE6
        else $error("peripheral buffer driven without select");

    a_periph_write: assert property (
        (mem_map_q[PERIPH_EN_POS] && periph_select_a && bus_wr)
        |=> (pa_out_q == $past(bus_wdata) && pa_oe_n_q == 8'h00)) // RULE5
        else $error("peripheral buffer did not carry bus data");

    a_addr_out: assert property (
        (!mem_map_q[PERIPH_EN_POS] && ctrl_b_q == ALL_PINS && dir_b_q == ALL_PINS && drv_b_q == 8'h00)
        |=> (pb_out_q == $past(latched_addr) && pb_oe_n_q == 8'h00)) // RULE4
        else $error("latched address not driven on port B");

    a_scan_pins: assert property (
        (pc_oe_n_q & PC_SCAN_MASK) == PC_SCAN_MASK) // RULE19
        else $error("scan pin driven as port");

    a_open_drain: assert property (
        drv_c_q[7] |=> (pc_oe_n_q[7] || !pc_out_q[7])) // RULE16
        else $error("open-drain pin drove high");

    a_fast_slew: assert property (
        pd_fast_slew_q == $past(drv_d_q & D_SLEW_MASK)) // RULE17
        else $error("slew select not following drive bit");
endmodule

/* File: verification/ppmc_pin_partner.sv */
module ppmc_pin_partner (
    input wire logic clock,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pull_up,
    input wire logic drive_en,
    input wire logic [7:0] drive_val,
    output logic [7:0] pin_level
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] last_q = 8'h00;

    // ****************************************
    // Wire resolution per pin
    // ****************************************
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_level[i] = pin_out[i];
            end else if (drive_en) begin
                pin_level[i] = drive_val[i];
            end else if (pull_up[i]) begin
                pin_level[i] = 1'b1;
            end else begin
                // Floating line shows a changing level
                pin_level[i] = ~last_q[i];
            end
        end
    end

    always @(posedge clock) begin
        last_q <= pin_level;
    end
endmodule

/* File: verification/programmable_port_mode_control_bench.sv */
module programmable_port_mode_control_bench
    import ppmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] bus_addr = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_wdata = 8'h00, bus_rdata_q, latched_addr = 8'h00;
    logic periph_select_a = 1'b0, periph_select_b = 1'b0;
    logic [7:0] periph_rdata_q;
    logic [7:0] data_out_a = 8'h00, data_out_b = 8'h00, data_out_c = 8'h00, data_out_d = 8'h00;
    logic [7:0] oe_term_a = 8'h00, oe_term_b = 8'h00, oe_term_c = 8'h00, oe_term_d = 8'h00;
    logic [7:0] cell_sel_a = 8'h00, cell_sel_b = 8'h00, cell_sel_c = 8'h00;
    logic [7:0] out_cell_group_first = 8'h00, out_cell_group_second = 8'h00;
    logic [7:0] pa_in, pa_out_q, pa_oe_n_q, pa_fast_slew_q, pb_out_q, pb_oe_n_q, pb_fast_slew_q;
    logic [7:0] pc_out_q, pc_oe_n_q, pd_out_q, pd_oe_n_q, pd_fast_slew_q;
    logic [7:0] pull_up = 8'h00, drive_val = 8'h00;
    logic drive_en = 1'b0;
    int n_fail = 0;
    int n_compared = 0;

    localparam logic [7:0] OFS_T [11] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_DIR_A, OFS_DIR_B, OFS_DIR_C,
        OFS_DIR_D, OFS_DRV_A, OFS_DRV_B, OFS_DRV_C, OFS_DRV_D, OFS_MEM_MAP};
    localparam logic [7:0] FULL_T [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, PD_IMPL_MASK,
        8'hFF, 8'hFF, 8'hFF, PD_IMPL_MASK, MEM_MAP_MASK};

    initial begin
        forever #5 clock = ~clock;
    end

    ppmc_port_ctrl u_dut (
        .clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .latched_addr(latched_addr),
        .periph_select_a(periph_select_a), .periph_select_b(periph_select_b),
        .periph_rdata_q(periph_rdata_q), .data_out_a(data_out_a), .data_out_b(data_out_b),
        .data_out_c(data_out_c), .data_out_d(data_out_d), .oe_term_a(oe_term_a),
        .oe_term_b(oe_term_b), .oe_term_c(oe_term_c), .oe_term_d(oe_term_d),
        .cell_sel_a(cell_sel_a), .cell_sel_b(cell_sel_b), .cell_sel_c(cell_sel_c),
        .out_cell_group_first(out_cell_group_first), .out_cell_group_second(out_cell_group_second),
        .pa_in(pa_in), .pa_out_q(pa_out_q), .pa_oe_n_q(pa_oe_n_q), .pa_fast_slew_q(pa_fast_slew_q),
        .pb_out_q(pb_out_q), .pb_oe_n_q(pb_oe_n_q), .pb_fast_slew_q(pb_fast_slew_q),
        .pc_out_q(pc_out_q), .pc_oe_n_q(pc_oe_n_q), .pd_out_q(pd_out_q), .pd_oe_n_q(pd_oe_n_q),
        .pd_fast_slew_q(pd_fast_slew_q)
    );

    ppmc_pin_partner u_partner (
        .clock(clock), .pin_out(pa_out_q), .pin_oe_n(pa_oe_n_q), .pull_up(pull_up),
        .drive_en(drive_en), .drive_val(drive_val), .pin_level(pa_in)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clock);
        bus_wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clock);
        bus_rd = 1'b0;
        check($sformatf("reg %h", a), exp, bus_rdata_q);
        @(negedge clock);
    endtask

    task automatic settle();
        repeat (2) @(negedge clock);
    endtask

    task automatic test_done(input string name);
        $display("test %s done", name);
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        n_fail++;
        give_verdict();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        for (int i = 0; i < 11; i++) reg_rd(OFS_T[i], CFG_RESET);
        reg_rd(8'h03, 8'h00);
        check("pa_oe_n", ALL_PINS, pa_oe_n_q);
        check("pa_slew", NO_PINS, pa_fast_slew_q);
        test_done("reset");

        for (int i = 0; i < 11; i++) reg_wr(OFS_T[i], 8'hFF);
        reg_wr(8'h03, 8'hFF);
        for (int i = 0; i < 11; i++) reg_rd(OFS_T[i], FULL_T[i]);
        reg_rd(8'h03, 8'h00);
        reg_wr(OFS_DIR_D, 8'hFB);
        reg_rd(OFS_DIR_D, 8'h02);
        for (int i = 0; i < 11; i++) reg_wr(OFS_T[i], 8'h00);
        test_done("readback");

        // Logic-array inputs keep direction zero
        reg_wr(OFS_DIR_A, 8'h01);
        data_out_a = 8'hA7;
        oe_term_a = 8'h02;
        cell_sel_a = 8'h02;
        oe_term_b = 8'h0C;
        cell_sel_b = 8'h0F;
        out_cell_group_second = 8'h05;
        data_out_b = 8'hFF;
        oe_term_d = 8'h02;
        data_out_d = 8'h02;
        settle();
        check("pa_oe_n", 8'hFC, pa_oe_n_q);
        check("pa_out", 8'h01, pa_out_q & 8'h03);
        check("pb_oe_n", 8'hF3, pb_oe_n_q);
        check("pb_out", 8'h04, pb_out_q & 8'h0C);
        check("pd_oe_n", 8'hFD, pd_oe_n_q);
        check("pd_out", 8'h02, pd_out_q & 8'h02);
        oe_term_b = 8'h00;
        cell_sel_a = 8'h00;
        cell_sel_b = 8'h00;
        oe_term_d = 8'h00;
        test_done("direction");

        reg_wr(OFS_CTRL_A, 8'hFF);
        reg_wr(OFS_DIR_A, 8'hF0);
        reg_wr(OFS_CTRL_B, 8'hFF);
        reg_wr(OFS_DIR_B, 8'hFF);
        oe_term_a = 8'h03;
        latched_addr = 8'h96;
        data_out_a = 8'h00;
        settle();
        check("pa_oe_n", 8'h0C, pa_oe_n_q);
        check("pa_out", 8'h92, pa_out_q & 8'hF3);
        check("pb_out", 8'h96, pb_out_q);
        reg_wr(OFS_CTRL_A, 8'h0F);
        settle();
        check("pa_out", 8'h02, pa_out_q & 8'hF3);
        reg_wr(OFS_CTRL_A, 8'h00);
        reg_wr(OFS_CTRL_B, 8'h00);
        reg_wr(OFS_DIR_B, 8'h00);
        oe_term_a = 8'h00;
        test_done("address");

        reg_wr(OFS_DIR_C, 8'hFF);
        cell_sel_c = 8'hFF;
        out_cell_group_second = 8'hAA;
        data_out_c = 8'h55;
        oe_term_c = 8'hFF;
        settle();
        check("pc_oe_n", PC_SCAN_MASK, pc_oe_n_q);
        check("pc_out", 8'h88, pc_out_q & PC_SECOND_MASK);
        reg_wr(OFS_DIR_C, 8'h00);
        oe_term_c = 8'h00;
        test_done("port_c");

        pull_up = AB_OD_MASK;
        reg_wr(OFS_DIR_A, 8'hFF);
        reg_wr(OFS_DRV_A, 8'hFF);
        reg_wr(OFS_DIR_D, 8'h06);
        reg_wr(OFS_DRV_D, 8'h06);
        reg_wr(OFS_DRV_B, 8'h05);
        reg_wr(OFS_DIR_C, 8'h80);
        reg_wr(OFS_DRV_C, 8'hFF);
        data_out_a = 8'h5A;
        settle();
        check("pa_oe_n", 8'h50, pa_oe_n_q);
        check("pb_slew", 8'h05, pb_fast_slew_q);
        check("pc_oe_n", ALL_PINS, pc_oe_n_q);
        check("pa_slew", AB_SLEW_MASK, pa_fast_slew_q);
        check("pd_slew", D_SLEW_MASK, pd_fast_slew_q);
        check("pd_oe_n", 8'hF9, pd_oe_n_q);
        for (int i = 6; i < 10; i++) reg_wr(OFS_T[i], 8'h00);
        reg_wr(OFS_DIR_A, 8'h00);
        reg_wr(OFS_DIR_D, 8'h00);
        reg_wr(OFS_DIR_C, 8'h00);
        pull_up = 8'h00;
        test_done("drive");

        reg_wr(OFS_MEM_MAP, MEM_MAP_MASK);
        settle();
        check("pa_oe_n", ALL_PINS, pa_oe_n_q);
        // Select terms qualified by the program strobe
        bus_addr = 8'h80;
        bus_wdata = 8'h3C;
        bus_wr = 1'b1;
        periph_select_a = 1'b1;
        @(negedge clock);
        check("pa_out", 8'h3C, pa_out_q);
        check("pa_oe_n", NO_PINS, pa_oe_n_q);
        bus_wr = 1'b0;
        periph_select_a = 1'b0;
        drive_en = 1'b1;
        drive_val = 8'hC3;
        repeat (3) @(negedge clock);
        check("pa_oe_n", ALL_PINS, pa_oe_n_q);
        bus_rd = 1'b1;
        periph_select_b = 1'b1;
        @(negedge clock);
        bus_rd = 1'b0;
        periph_select_b = 1'b0;
        check("periph_rdata", 8'hC3, periph_rdata_q);
        check("bus_rdata", 8'h00, bus_rdata_q);
        drive_en = 1'b0;
        reg_wr(OFS_MEM_MAP, 8'h00);
        test_done("peripheral");
        give_verdict();
    end
endmodule
